//--- verilog/sasg_top.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Receive byte buffer
// ----------------------------------------------------------------
module sasg_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_wr_valid,
    output logic              o_wr_ready,
    input  wire logic [W-1:0] i_wr_data,
    output logic              o_rd_valid,
    input  wire logic         i_rd_ready,
    output logic [W-1:0]      o_rd_data
);
    import sasg_pkg::*;
    localparam int AW = $clog2(D);
    if (D < 2 || (1 << AW) != D) begin : g_bad_depth
        $error("sasg_fifo: depth must be a power of two");
    end
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [AW:0]   cnt_r;
    wire do_wr = i_wr_valid && o_wr_ready;
    wire do_rd = o_rd_valid && i_rd_ready;
    assign o_wr_ready = (cnt_r != (AW+1)'(D));
    assign o_rd_valid = (cnt_r != '0);
    assign o_rd_data  = mem_r[rptr_r];
    always_ff @(posedge i_clk) begin
        if (do_wr) mem_r[wptr_r] <= i_wr_data;
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r  <= '0;
        end else begin
            if (do_wr) wptr_r <= wptr_r + 1'b1;
            if (do_rd) rptr_r <= rptr_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

// ----------------------------------------------------------------
// Alarm supervision and serial command gating
// ----------------------------------------------------------------
module sasg_top #(
    parameter int P_FLASH_CYC = sasg_pkg::FLASH_CYC,
    parameter int P_BIT_CYC   = sasg_pkg::BIT_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [4:0]  i_fault,
    input  wire logic        i_rxd,
    output logic             o_txd,
    input  wire logic [6:0]  i_drive_id,
    input  wire logic        i_busy,
    input  wire logic        i_in_pos,
    input  wire logic [15:0] i_pos_single,
    input  wire logic [31:0] i_pos_multi,
    input  wire logic        i_ext_step_valid,
    input  wire logic [15:0] i_ext_step,
    input  wire logic        i_fb_step_valid,
    input  wire logic [15:0] i_fb_step,
    output logic             o_motor_pwr_en,
    output logic             o_loop_en,
    output logic             o_alarm,
    output logic             o_fault_indicator_lamp,
    output logic [4:0]       o_fault_latched,
    output logic [6:0]       o_config,
    output logic [31:0]      o_target_pos,
    output logic [1:0]       o_move_kind,
    output logic             o_live_target_update,
    output logic [31:0]      o_pos_err,
    output logic             o_rx_overrun
);
    import sasg_pkg::*;
    if (P_FLASH_CYC < 1 || P_FLASH_CYC >= (1 << FLASH_W)) begin : g_bad
        $error("sasg_top: flash period out of range");
    end
    if (P_BIT_CYC < 8 || P_BIT_CYC >= (1 << CNT_W)) begin : g_bad_bit
        $error("sasg_top: bit period out of range");
    end

    function automatic logic is_motion(input logic [4:0] fn);
        return fn == FN_GO_ABS || fn == FN_GO_REL ||
               fn == FN_LINE || fn == FN_ARC;
    endfunction

    // ------------------------------------------------------------
    // Fault latch and indicator
    // ------------------------------------------------------------
    logic [4:0] flt_m_r;
    logic [4:0] flt_s_r;
    logic [FLASH_W-1:0] flash_r;
    wire [4:0] flt_nxt   = o_fault_latched | flt_s_r;
    wire       alarm_nxt = |flt_nxt;
    wire       cfg_en    = o_config[CFG_EN_BIT];
    wire [2:0] cmd_mode  = o_config[CFG_CMD_LSB +: 3];
    wire       flash_end = (flash_r == FLASH_W'(P_FLASH_CYC - 1));
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            flt_m_r         <= '0;
            flt_s_r         <= '0;
            o_fault_latched <= '0;
            o_alarm         <= 1'b0;
            o_motor_pwr_en  <= 1'b0;
            o_loop_en       <= 1'b0;
        end else begin
            flt_m_r         <= i_fault;
            flt_s_r         <= flt_m_r;
            o_fault_latched <= flt_nxt;
            o_alarm         <= alarm_nxt;
            o_motor_pwr_en  <= cfg_en && !alarm_nxt;
            o_loop_en       <= cfg_en && !alarm_nxt;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !alarm_nxt) begin
            flash_r                <= '0;
            o_fault_indicator_lamp <= 1'b0;
        end else begin
            flash_r <= flash_end ? '0 : flash_r + 1'b1;
            if (flash_end)
                o_fault_indicator_lamp <= !o_fault_indicator_lamp;
        end
    end

    // ------------------------------------------------------------
    // Position error accumulator
    // ------------------------------------------------------------
    wire [31:0] ext_d = (i_ext_step_valid && cmd_mode != CMD_SERIAL) ?
                        {{16{i_ext_step[15]}}, i_ext_step} : '0;
    wire [31:0] fb_d  = i_fb_step_valid ?
                        {{16{i_fb_step[15]}}, i_fb_step} : '0;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            o_pos_err <= '0;
        else if (!o_alarm)
            o_pos_err <= o_pos_err + ext_d - fb_d;
    end

    // ------------------------------------------------------------
    // Serial receiver, 8N1
    // ------------------------------------------------------------
    logic [1:0]       rxd_sync_r;
    logic             rx_busy_r;
    logic [CNT_W-1:0] rx_cnt_r;
    logic [3:0]       rx_bit_r;
    logic [7:0]       rx_sh_r;
    logic             rx_done_r;
    wire rxd_s = rxd_sync_r[1];
    wire rx_tick = (rx_cnt_r == '0);
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rxd_sync_r <= 2'b11;
            rx_busy_r  <= 1'b0;
            rx_cnt_r   <= '0;
            rx_bit_r   <= '0;
            rx_sh_r    <= '0;
            rx_done_r  <= 1'b0;
        end else begin
            rxd_sync_r <= {rxd_sync_r[0], i_rxd};
            rx_done_r  <= 1'b0;
            if (!rx_busy_r) begin
                if (!rxd_s) begin
                    rx_busy_r <= 1'b1;
                    rx_cnt_r  <= CNT_W'(P_BIT_CYC / 2);
                    rx_bit_r  <= '0;
                end
            end else if (!rx_tick) begin
                rx_cnt_r <= rx_cnt_r - 1'b1;
            end else begin
                rx_cnt_r <= CNT_W'(P_BIT_CYC - 1);
                rx_bit_r <= rx_bit_r + 1'b1;
                if (rx_bit_r == 4'd0 && rxd_s)
                    rx_busy_r <= 1'b0;
                else if (rx_bit_r == 4'd9) begin
                    rx_busy_r <= 1'b0;
                    rx_done_r <= rxd_s;
                end else if (rx_bit_r != 4'd0)
                    rx_sh_r <= {rxd_s, rx_sh_r[7:1]};
            end
        end
    end

    // ------------------------------------------------------------
    // Buffer and packet parser
    // ------------------------------------------------------------
    logic             fifo_wr_ready;
    logic             fifo_rd_valid;
    logic [7:0]       b;
    logic [2:0]       rep_left_r;
    logic             tx_busy_r;
    logic             exec_r;
    wire take = fifo_rd_valid && rep_left_r == '0 && !tx_busy_r && !exec_r;
    sasg_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_wr_valid (rx_done_r),
        .o_wr_ready (fifo_wr_ready),
        .i_wr_data  (rx_sh_r),
        .o_rd_valid (fifo_rd_valid),
        .i_rd_ready (take),
        .o_rd_data  (b)
    );
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            o_rx_overrun <= 1'b0;
        else if (rx_done_r && !fifo_wr_ready)
            o_rx_overrun <= 1'b1;
    end

    sasg_pstate_e ps_r;
    logic [4:0]  fn_r;
    logic        id_ok_r;
    logic        bcast_r;
    logic        first_r;
    logic [2:0]  left_r;
    logic [27:0] acc_r;
    logic [6:0]  sum_r;
    wire [6:0] sum_nxt = sum_r + b[6:0];
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ps_r    <= PS_IDLE;
            fn_r    <= '0;
            id_ok_r <= 1'b0;
            bcast_r <= 1'b0;
            first_r <= 1'b0;
            left_r  <= '0;
            acc_r   <= '0;
            sum_r   <= '0;
            exec_r  <= 1'b0;
        end else begin
            exec_r <= 1'b0;
            if (take && !b[7]) begin
                ps_r    <= PS_FUNC;
                id_ok_r <= b[6:0] == i_drive_id || b[6:0] == BCAST_ID;
                bcast_r <= b[6:0] == BCAST_ID;
                sum_r   <= b[6:0];
            end else if (take) begin
                case (ps_r)
                    PS_FUNC: begin
                        fn_r    <= b[4:0];
                        left_r  <= {1'b0, b[6:5]} + 3'd1;
                        sum_r   <= sum_nxt;
                        first_r <= 1'b1;
                        ps_r    <= PS_DATA;
                    end
                    PS_DATA: begin
                        acc_r   <= first_r ? {{21{b[6]}}, b[6:0]} :
                                             {acc_r[20:0], b[6:0]};
                        first_r <= 1'b0;
                        sum_r   <= sum_nxt;
                        left_r  <= left_r - 1'b1;
                        if (left_r == 3'd1) ps_r <= PS_CSUM;
                    end
                    PS_CSUM: begin
                        ps_r   <= PS_IDLE;
                        exec_r <= id_ok_r && b[6:0] == sum_r;
                    end
                    default: ps_r <= PS_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Command execution
    // ------------------------------------------------------------
    wire mv_ok = exec_r && is_motion(fn_r) && cmd_mode == CMD_SERIAL &&
                 !o_alarm;
    wire [31:0] acc_x = {{4{acc_r[27]}}, acc_r};
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_config             <= CFG_RST;
            o_target_pos         <= '0;
            o_move_kind          <= MV_ABS;
            o_live_target_update <= 1'b0;
        end else begin
            o_live_target_update <= mv_ok;
            if (mv_ok) begin
                o_target_pos <= (fn_r == FN_GO_REL) ?
                                o_target_pos + acc_x : acc_x;
                case (fn_r)
                    FN_GO_REL: o_move_kind <= MV_REL;
                    FN_LINE:   o_move_kind <= MV_LINE;
                    FN_ARC:    o_move_kind <= MV_ARC;
                    default:   o_move_kind <= MV_ABS;
                endcase
            end
            if (exec_r && fn_r == FN_SET_CFG)
                o_config <= acc_r[6:0];
        end
    end

    // ------------------------------------------------------------
    // Reply assembly and transmitter
    // ------------------------------------------------------------
    logic [1:0]  rep_n;
    logic [20:0] rep_val;
    logic        rep_go;
    always_comb begin
        rep_go  = exec_r && !bcast_r;
        rep_n   = 2'd1;
        rep_val = '0;
        case (fn_r)
            FN_RD_CFG:  rep_val = {14'h0000, o_config};
            FN_RD_STAT: begin
                rep_n   = 2'd2;
                rep_val = {7'h00, o_alarm, i_busy, i_in_pos, cfg_en,
                           3'h0, 2'h0, o_fault_latched};
            end
            FN_RD_POS: begin
                rep_n   = 2'd3;
                rep_val = {5'h00, acc_r[0] ? i_pos_multi[31:16] :
                                             i_pos_single};
            end
            default: rep_go = 1'b0;
        endcase
    end
    wire [23:0] rep_dat = {1'b1, rep_val[20:14], 1'b1, rep_val[13:7],
                           1'b1, rep_val[6:0]};
    wire [4:0]  sh_amt  = 5'({3'd3 - {1'b0, rep_n}, 3'b000});
    wire [23:0] rep_tail = rep_dat << sh_amt;
    wire [1:0]  rep_len  = rep_n - 2'd1;

    logic [39:0]      rep_q_r;
    logic [6:0]       tx_sum_r;
    logic [9:0]       tx_sh_r;
    logic [3:0]       tx_bit_r;
    logic [CNT_W-1:0] tx_cnt_r;
    wire [7:0] tx_byte = (rep_left_r == 3'd1) ? {1'b1, tx_sum_r} :
                                                rep_q_r[39:32];
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rep_q_r    <= '0;
            rep_left_r <= '0;
            tx_sum_r   <= '0;
            tx_sh_r    <= '1;
            tx_bit_r   <= '0;
            tx_cnt_r   <= '0;
            tx_busy_r  <= 1'b0;
            o_txd      <= 1'b1;
        end else if (rep_go) begin
            rep_q_r    <= {1'b0, i_drive_id, 1'b1, rep_len, fn_r,
                           rep_tail};
            rep_left_r <= {1'b0, rep_n} + 3'd3;
            tx_sum_r   <= '0;
        end else if (!tx_busy_r && rep_left_r != '0) begin
            tx_sh_r    <= {1'b1, tx_byte, 1'b0};
            tx_sum_r   <= tx_sum_r + tx_byte[6:0];
            rep_q_r    <= {rep_q_r[31:0], 8'h00};
            rep_left_r <= rep_left_r - 1'b1;
            tx_bit_r   <= '0;
            tx_cnt_r   <= '0;
            tx_busy_r  <= 1'b1;
        end else if (tx_busy_r) begin
            if (tx_cnt_r == '0) begin
                tx_cnt_r <= CNT_W'(P_BIT_CYC - 1);
                if (tx_bit_r == 4'd10) begin
                    tx_busy_r <= 1'b0;
                end else begin
                    o_txd    <= tx_sh_r[0];
                    tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
                    tx_bit_r <= tx_bit_r + 1'b1;
                end
            end else begin
                tx_cnt_r <= tx_cnt_r - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_fault_hit;
        alarm_nxt;
    endsequence
    sequence s_power_gone;
        !o_motor_pwr_en && !o_loop_en;
    endsequence
    property p_alarm_cuts_power;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_fault_hit |=> s_power_gone;
    endproperty
    a_alarm_cuts_power: assert property (p_alarm_cuts_power)
        else $error("motor power stayed on after fault");
    property p_alarm_sticky;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_alarm |=> o_alarm [*3];
    endproperty
    a_alarm_sticky: assert property (p_alarm_sticky)
        else $error("alarm cleared without reset");
    property p_fault_latched;
        @(posedge i_clk) disable iff (!i_rst_n)
        flt_s_r[FLT_OCURR] |=> o_fault_latched[FLT_OCURR] && o_alarm;
    endproperty
    a_fault_latched: assert property (p_fault_latched)
        else $error("fault input not latched");
    property p_lamp_dark;
        @(posedge i_clk) disable iff (!i_rst_n)
        !o_alarm |-> !o_fault_indicator_lamp;
    endproperty
    a_lamp_dark: assert property (p_lamp_dark)
        else $error("lamp lit without alarm");
    property p_no_move_in_alarm;
        @(posedge i_clk) disable iff (!i_rst_n)
        $past(o_alarm) |-> !o_live_target_update && $stable(o_pos_err);
    endproperty
    a_no_move_in_alarm: assert property (p_no_move_in_alarm)
        else $error("motion accepted during alarm");
    property p_serial_move;
        @(posedge i_clk) disable iff (!i_rst_n)
        exec_r && is_motion(fn_r) && cmd_mode == CMD_SERIAL && !o_alarm
        |=> o_live_target_update;
    endproperty
    a_serial_move: assert property (p_serial_move)
        else $error("serial move not applied");
    property p_other_mode_no_move;
        @(posedge i_clk) disable iff (!i_rst_n)
        exec_r && cmd_mode != CMD_SERIAL |=> !o_live_target_update;
    endproperty
    a_other_mode_no_move: assert property (p_other_mode_no_move)
        else $error("serial move outside serial mode");
    property p_reply_only_on_request;
        @(posedge i_clk) disable iff (!i_rst_n)
        rep_left_r != '0 && $past(rep_left_r) == '0 |-> $past(exec_r);
    endproperty
    a_reply_only_on_request: assert property (p_reply_only_on_request)
        else $error("reply without request");
    property p_status_in_alarm;
        @(posedge i_clk) disable iff (!i_rst_n)
        exec_r && !bcast_r && fn_r == FN_RD_STAT |=> rep_left_r == 3'd5;
    endproperty
    a_status_in_alarm: assert property (p_status_in_alarm)
        else $error("status read not answered");
endmodule

`default_nettype wire

//--- pkg/sasg_pkg.sv
// Summary of operation
// - Five fault inputs each raise the alarm
// - Status lamp flashes while alarm is latched
// - Alarm cuts motor power and servo loop
// - Logic and serial port keep running in alarm
// - Alarm discards motion commands, error accumulator frozen
// - Alarm clears only by power-on reset
// - Serial port active from reset in every mode
// - Serial mode executes serial position commands
// - Other modes: serial does parameters and status only
// - Host is master; device answers only requests
// - New target accepted mid-move, applied at once
// - Status readable: alarm, busy, in-position, enable
// - Config readable: servo, abs/rel, command mode, enable
// - Position read: 16-bit single, or upper 16 bits of multi-turn
// - Moves: absolute, relative, linear, circular kinds
// - Bytes 38400 baud, start, eight data, stop
// - Start byte MSB clear, later bytes MSB set
// - No acknowledge; execute, answer or store directly
package sasg_pkg;
    localparam int CLK_HZ     = 100_000_000;
    localparam int BAUD       = 38400;
    localparam int BIT_CYC    = CLK_HZ / BAUD;
    localparam int HALF_CYC   = BIT_CYC / 2;
    localparam int CNT_W      = 12;
    localparam int FLASH_MS   = 250;
    localparam int FLASH_CYC  = CLK_HZ / 1000 * FLASH_MS;
    localparam int FLASH_W    = 25;
    localparam int NUM_FAULTS = 5;
    localparam int FIFO_DEPTH = 32;
    localparam int BYTE_W     = 8;
    // Fault bit positions
    localparam int FLT_OVOLT  = 0;
    localparam int FLT_OTEMP  = 1;
    localparam int FLT_LPHASE = 2;
    localparam int FLT_OPOWER = 3;
    localparam int FLT_OCURR  = 4;
    localparam logic [6:0] BCAST_ID = 7'h7f;
    // Function codes
    localparam logic [4:0] FN_GO_ABS  = 5'h01;
    localparam logic [4:0] FN_LINE    = 5'h02;
    localparam logic [4:0] FN_GO_REL  = 5'h03;
    localparam logic [4:0] FN_ARC     = 5'h04;
    localparam logic [4:0] FN_SET_CFG = 5'h07;
    localparam logic [4:0] FN_RD_CFG  = 5'h08;
    localparam logic [4:0] FN_RD_STAT = 5'h09;
    localparam logic [4:0] FN_RD_POS  = 5'h0e;
    // Configuration byte layout
    localparam int CFG_EN_BIT  = 0;
    localparam int CFG_CMD_LSB = 1;
    localparam int CFG_ABS_BIT = 4;
    localparam int CFG_SRV_LSB = 5;
    localparam logic [6:0] CFG_RST = 7'h00;
    localparam logic [2:0] CMD_SERIAL = 3'h0;
    typedef enum logic [1:0] {
        MV_ABS  = 2'b00,
        MV_REL  = 2'b01,
        MV_LINE = 2'b10,
        MV_ARC  = 2'b11
    } sasg_move_e;
    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_FUNC = 2'b01,
        PS_DATA = 2'b11,
        PS_CSUM = 2'b10
    } sasg_pstate_e;
endpackage

//--- test/sasg_host.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Host controller acting as serial master
// ----------------------------------------------------------------
module sasg_host #(
    parameter int P_BIT_CYC = sasg_pkg::BIT_CYC
) (
    input  wire logic  i_clk,
    input  wire logic  i_txd,
    output logic       o_rxd,
    output logic       o_rx_valid,
    output logic [7:0] o_rx_data
);
    import sasg_pkg::*;
    logic [7:0] sh;
    initial begin
        o_rxd = 1'b1;
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
    end
    // Line idles high; only the host ever starts an exchange
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_rxd <= fr[i];
            repeat (P_BIT_CYC) @(posedge i_clk);
        end
    endtask
    // A bad stop bit hands on the inverted byte so the bench sees it
    always begin
        @(negedge i_txd);
        repeat (P_BIT_CYC / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (P_BIT_CYC) @(posedge i_clk);
            sh[i] = i_txd;
        end
        repeat (P_BIT_CYC) @(posedge i_clk);
        o_rx_data <= i_txd ? sh : ~sh;
        o_rx_valid <= 1'b1;
        @(posedge i_clk);
        o_rx_valid <= 1'b0;
    end
endmodule
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Alarm and serial gating bench
// ----------------------------------------------------------------
module tb;
    import sasg_pkg::*;
    localparam int         FL = 8;
    // Short bit time keeps the run small; the link logic is unchanged
    localparam int         BC = 32;
    localparam logic [6:0] ID = 7'h01;
    localparam logic [4:0] MV [4] = '{FN_GO_ABS, FN_GO_REL, FN_LINE, FN_ARC};
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [4:0]  i_fault = 5'h00;
    logic        ev = 1'b0;
    logic [15:0] ea = 16'h0000;
    logic [15:0] fa = 16'h0000;
    logic        busy, in_pos, rxd, txd, rx_v, pwr, lp, alarm, lamp, upd;
    logic        ovr, lv;
    logic [7:0]  rx_d;
    logic [4:0]  flt;
    logic [6:0]  cfg, e_cfg, v;
    logic [1:0]  kind;
    logic [31:0] pos, tgt, err, e_tgt, e_err, sv;
    logic [7:0]  exp_b [$];
    logic [33:0] exp_t [$];
    logic [7:0]  pk [$];
    int          fails = 0;
    int          cmp_count = 0;

    always #5 i_clk = ~i_clk;

    sasg_top #(.P_FLASH_CYC(FL), .P_BIT_CYC(BC)) u_sasg_top (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_fault(i_fault), .i_rxd(rxd),
        .o_txd(txd), .i_drive_id(ID), .i_busy(busy), .i_in_pos(in_pos),
        .i_pos_single(pos[15:0]), .i_pos_multi(pos),
        .i_ext_step_valid(ev), .i_ext_step(ea), .i_fb_step_valid(ev),
        .i_fb_step(fa), .o_motor_pwr_en(pwr), .o_loop_en(lp),
        .o_alarm(alarm), .o_fault_indicator_lamp(lamp),
        .o_fault_latched(flt), .o_config(cfg), .o_target_pos(tgt),
        .o_move_kind(kind), .o_live_target_update(upd), .o_pos_err(err),
        .o_rx_overrun(ovr));
    sasg_host #(.P_BIT_CYC(BC)) u_sasg_host (.i_clk(i_clk), .i_txd(txd),
        .o_rxd(rxd), .o_rx_valid(rx_v), .o_rx_data(rx_d));

    task automatic stop_test();
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Replies and target loads are matched in arrival order
    always @(negedge i_clk) begin
        if (rx_v === 1'b1)
            chk_b(rx_d, exp_b.size() ? exp_b.pop_front() : 'x);
        if (upd === 1'b1)
            chk({kind, tgt}, exp_t.size() ? exp_t.pop_front() : 'x);
    end
    function automatic void mk(input logic [4:0] fn, input int n,
                               input logic [27:0] d);
        logic [6:0] s;
        pk.delete();
        pk.push_back({1'b0, ID});
        pk.push_back({1'b1, 2'(n - 1), fn});
        for (int k = n - 1; k >= 0; k--)
            pk.push_back({1'b1, d[7*k +: 7]});
        s = 7'h00;
        foreach (pk[j]) s += pk[j][6:0];
        pk.push_back({1'b1, s});
    endfunction
    task automatic send(input logic [4:0] fn, input logic [27:0] d);
        mk(fn, 1, d);
        @(posedge i_clk);
        foreach (pk[j]) u_sasg_host.send_byte(pk[j]);
    endtask
    task automatic reply(input logic [4:0] fn, input int n,
                         input logic [27:0] d, input logic [27:0] q);
        int t;
        mk(fn, n, d);
        foreach (pk[j]) exp_b.push_back(pk[j]);
        send(fn, q);
        for (t = 0; t < 8000 && exp_b.size() > 0; t++) @(posedge i_clk);
        if (t == 8000) begin
            fails++;
            stop_test();
        end
    endtask
    task automatic do_reset();
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        i_fault <= 5'h00;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        e_tgt = 32'h0000_0000;
        e_err = 32'h0000_0000;
        e_cfg = 7'h00;
        #1 chk(34'({txd, alarm, lamp, pwr, lp, flt, cfg, kind, upd, ovr}),
               34'({1'b1, 20'h0_0000}));
        chk(34'(tgt | err), 34'h0_0000_0000);
    endtask
    // Ext steps count only outside serial mode; feedback counts in every mode; neither counts in alarm
    task automatic step(input logic on);
        logic [15:0] a;
        logic [15:0] b;
        a = 16'($urandom);
        b = 16'($urandom);
        @(posedge i_clk);
        ea <= a;
        fa <= b;
        ev <= 1'b1;
        @(posedge i_clk);
        ev <= 1'b0;
        if (on)
            e_err = e_err - {{16{b[15]}}, b} + ((e_cfg[3:1] != CMD_SERIAL)
                    ? {{16{a[15]}}, a} : 32'h0000_0000);
    endtask
    function automatic logic [27:0] stat(input logic a, input logic [4:0] f);
        return 28'({a, busy, in_pos, e_cfg[0], 5'h00, f});
    endfunction

    initial begin
        void'($urandom(32'h7022_1f9f));
        busy <= 1'($urandom);
        in_pos <= 1'($urandom);
        pos <= $urandom;
        do_reset();
        for (int k = 0; k < NUM_FAULTS; k++) begin
            @(posedge i_clk);
            i_fault <= 5'(1 << k);
            repeat (4) @(posedge i_clk);
            i_fault <= 5'h00;
            #1 chk(34'({alarm, flt}), 34'({1'b1, 5'(1 << k)}));
            repeat (6) @(posedge i_clk);
            #1 chk(34'({alarm, flt}), 34'({1'b1, 5'(1 << k)}));
            do_reset();
        end
        e_cfg = 7'h01;
        send(FN_SET_CFG, 28'(e_cfg));
        #1 chk(34'({cfg, pwr, lp}), 34'({e_cfg, 2'b11}));
        reply(FN_RD_CFG, 1, 28'(e_cfg), 28'h000_0000);
        foreach (MV[i]) begin
            v = 7'($urandom);
            sv = {{25{v[6]}}, v};
            e_tgt = (MV[i] == FN_GO_REL) ? e_tgt + sv : sv;
            exp_t.push_back({2'(i), e_tgt});
            send(MV[i], 28'(v));
        end
        #1 chk(34'(exp_t.size()), 34'h0_0000_0000);
        reply(FN_RD_STAT, 2, stat(1'b0, 5'h00), 28'h000_0000);
        for (int s = 0; s < 2; s++)
            reply(FN_RD_POS, 3, 28'(s ? pos[31:16] : pos[15:0]), 28'(s));
        e_cfg = 7'h03;
        send(FN_SET_CFG, 28'(e_cfg));
        send(FN_GO_ABS, 28'($urandom));
        reply(FN_RD_CFG, 1, 28'(e_cfg), 28'h000_0000);
        repeat (4) step(1'b1);
        repeat (3) @(posedge i_clk);
        #1 chk(34'(err), 34'(e_err));
        e_cfg = 7'h01;
        send(FN_SET_CFG, 28'(e_cfg));
        @(posedge i_clk);
        i_fault <= 5'h08;
        repeat (4) @(posedge i_clk);
        #1 chk(34'({alarm, pwr, lp, flt}), 34'({3'b100, 5'h08}));
        lv = lamp;
        repeat (FL) @(posedge i_clk);
        #1 chk(34'(lamp), 34'({~lv}));
        repeat (4) step(1'b0);
        send(FN_GO_ABS, 28'($urandom));
        reply(FN_RD_STAT, 2, stat(1'b1, 5'h08), 28'h000_0000);
        #1 chk(34'({ovr, err}), 34'({1'b0, e_err}));
        do_reset();
        stop_test();
    end
endmodule
`default_nettype wire
